// ===== inc/rfrt_pkg.sv
// Shared constants for the receive FIFO read path and RAM test mode
package rfrt_pkg;
	// ==================================================
	// Device map (byte addresses on the host link)
	localparam logic [7:0] DEV_CFG    = 8'h04;
	localparam logic [7:0] DEV_PART   = 8'h08;
	localparam logic [7:0] DEV_TXSTAT = 8'h0C;
	localparam logic [7:0] DEV_RXSTAT = 8'h10;
	localparam logic [7:0] DEV_RXDATA = 8'hC0;
	// Config register fields
	localparam int CFG_SNOOP   = 0;
	localparam int CFG_TRG_EN  = 1;
	localparam int CFG_FLUSH   = 2;
	localparam int CFG_TRG_LSB = 8;
	// Transmit FIFO status register fields
	localparam int TX_MISMATCH  = 2;
	localparam int TX_ADR_CLEAR = 3;
	localparam int TX_CTRLVAL   = 4;
	localparam int TX_TEST_EN   = 5;
	localparam int TX_ADR_LSB   = 16;
	// Receive status register fields
	localparam int RX_PKT_DONE = 0;
	localparam int RX_HEADFLAG = 1;
	localparam int RX_CNT_LSB  = 16;
	// Partition register fields
	localparam int PART_ISO_LSB = 16;
	// ==================================================
	// RAM and token layout
	localparam int RAM_DEPTH = 512;
	localparam int AW        = 9;
	localparam int CTRL_BIT  = 32;
	localparam int TK_ACKS   = 7;
	localparam int TK_PCOMP  = 11;
	localparam int TK_SNOOP  = 12;
	localparam int TK_SPD    = 13;
	localparam int TK_CNT    = 15;
	localparam int TK_TCODE  = 24;
	localparam int TK_ACK    = 28;
	localparam logic [3:0] TCODE_SPECIAL = 4'hE;
	localparam logic [3:0] ACK_NONE      = 4'h0;
	localparam logic [8:0] TRG_MIN       = 9'h005;
	// Reset values
	localparam logic [31:0] CFG_RST  = 32'h0000_0000;
	localparam logic [31:0] PART_RST = 32'h0040_0040;
	// Kind of received packet
	typedef enum logic [1:0] {
		RFRT_PK_NORMAL = 2'h0,
		RFRT_PK_SELFID = 2'h1,
		RFRT_PK_PHYLNK = 2'h2
	} rfrt_kind_t;
	// ==================================================
	// Host-side APB map
	localparam logic [7:0] HB_CMD    = 8'h00;
	localparam logic [7:0] HB_WDATA  = 8'h04;
	localparam logic [7:0] HB_RDATA  = 8'h08;
	localparam logic [7:0] HB_STATUS = 8'h0C;
	localparam int HB_CMD_WR = 8;
	localparam int HB_ST_BUSY = 0;
	localparam int HB_ST_IRQ  = 1;
	localparam int HB_ST_REF  = 2;
	localparam int HB_ST_TEST = 3;
endpackage : rfrt_pkg

// ===== inc/rfrt_if.sv
// Host link between the bus master and the link controller
`timescale 1ns/1ns
`default_nettype none
interface rfrt_if;
	logic        cs;
	logic        wr;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        ack;
	logic        rx_irq;
	modport dev  (input cs, wr, addr, wdata, output rdata, ack, rx_irq);
	modport host (output cs, wr, addr, wdata, input rdata, ack, rx_irq);
endinterface : rfrt_if
`default_nettype wire

// ===== rtl/rfrt_dev.sv
// Link controller end: receive FIFO with block tokens and RAM test access
// What this block does
// - Host reads receive data at C0h, bursts allowed
// - Data-ready interrupt when stored blocks are ready
// - Head flag marks token; token then count quadlets
// - Bits 7-10 snooped ack, else zero
// - Bit 11 is packet-complete
// - Bit 12 mirrors snoop enable
// - Bits 13-14 receive speed code
// - Bits 15-23 quadlet count of block
// - Bits 24-27 tcode, special packets report 1110
// - Bits 28-31 ack; PHY/link-on report zero
// - Trigger blocking needs enable, no flush, size>5
// - No blocking for special or quadlet packets
// - Test mode: direct RAM access, status frozen
// - Bit 5 enters test mode, clearing resumes
// - Test access at C0h uses counter, increments
// - RAM is 512 words of 33 bits
// - Test write stores data plus control value
// - Test read compares control bit, sets mismatch
// - Address clear zeroes counter and mismatch, self-clears
// - Written counter selects next location, reads back
// - Stored bit is the control value from bit 4
// - Receive region starts after both transmit regions
// - Control bit 1 only on first quadlet
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module rfrt_dev (
	// Clock and reset
	input  wire logic               REF_CLK,
	input  wire logic               SRST,
	// Host link
	rfrt_if.dev                     BUS,
	// Received packet stream from the link core
	input  wire logic               RX_VALID,
	input  wire logic               RX_FIRST,
	input  wire logic               RX_LAST,
	input  wire logic [31:0]        RX_DATA,
	input  wire logic [3:0]         RX_TCODE,
	input  wire logic [1:0]         RX_SPEED,
	input  wire rfrt_pkg::rfrt_kind_t RX_KIND,
	input  wire logic               RX_QUAD_PKT,
	input  wire logic [3:0]         RX_ACK,
	input  wire logic [3:0]         RX_SNOOP_ACK,
	output logic                    RX_READY
);
	import rfrt_pkg::*;

	typedef enum logic [2:0] {
		RFRT_IDLE  = 3'b001,
		RFRT_RECV  = 3'b010,
		RFRT_TOKEN = 3'b100
	} rfrt_state_t;

	// ==================================================
	// Storage and registers
	logic [CTRL_BIT:0] ram [RAM_DEPTH];
	logic [31:0]       cfg;
	logic [31:0]       part;
	logic              ram_test_enable;
	logic              test_control_value;
	logic              control_mismatch_flag;
	logic [AW-1:0]     test_adr;
	rfrt_state_t       state;
	logic [AW-1:0]     wp, rp, cp, tok_slot, fill, cnt;
	logic [3:0]        tcode, ack, snp_ack;
	logic [1:0]        spd;
	logic              pcomp, blocking;

	logic [AW-1:0] base, rsize, trg_size;
	logic          trg_ok, acc, take, rd_recv, last_q, ready_blk;
	logic [AW-1:0] head;

	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p, input logic [AW-1:0] sz);
		nxt = (p + 9'h001 == sz) ? 9'h000 : p + 9'h001;
	endfunction : nxt

	assign base     = part[AW-1:0] + part[PART_ISO_LSB +: AW];
	assign rsize    = 9'(RAM_DEPTH - int'(base));
	assign head     = base + rp;
	assign trg_size = cfg[CFG_TRG_LSB +: AW];
	assign trg_ok   = cfg[CFG_TRG_EN] && !cfg[CFG_FLUSH] && trg_size > TRG_MIN;
	assign acc      = BUS.cs && !BUS.ack;
	assign take     = RX_VALID && RX_READY;
	assign ready_blk = rp != cp;
	assign rd_recv  = acc && !BUS.wr && BUS.addr == DEV_RXDATA && !ram_test_enable && ready_blk;
	// Block closes on the packet end or when the trigger size is reached
	assign last_q   = RX_LAST || (blocking && cnt + 9'h001 == trg_size);

	// ==================================================
	// Configuration and test control
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			cfg  <= CFG_RST;
			part <= PART_RST;
		end else if (acc && BUS.wr && BUS.addr == DEV_CFG) begin
			cfg <= BUS.wdata;
		end else if (acc && BUS.wr && BUS.addr == DEV_PART && !ram_test_enable) begin
			part <= BUS.wdata;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			ram_test_enable       <= 1'b0;
			test_control_value    <= 1'b0;
			control_mismatch_flag <= 1'b0;
			test_adr              <= '0;
		end else if (acc && BUS.wr && BUS.addr == DEV_TXSTAT) begin
			ram_test_enable    <= BUS.wdata[TX_TEST_EN];
			test_control_value <= BUS.wdata[TX_CTRLVAL];
			if (BUS.wdata[TX_ADR_CLEAR]) begin
				test_adr              <= '0;
				control_mismatch_flag <= 1'b0;
			end else begin
				test_adr <= BUS.wdata[TX_ADR_LSB +: AW];
			end
		end else if (acc && ram_test_enable && BUS.addr == DEV_RXDATA) begin
			test_adr <= test_adr + 9'h001;
			// Mismatch is sticky; it never stops further accesses
			if (!BUS.wr && ram[test_adr][CTRL_BIT] != test_control_value)
				control_mismatch_flag <= 1'b1;
		end
	end

	// ==================================================
	// RAM write port: test writes or receive path
	always_ff @(posedge REF_CLK) begin
		if (acc && BUS.wr && BUS.addr == DEV_RXDATA && ram_test_enable) begin
			ram[test_adr] <= {test_control_value, BUS.wdata};
		end else if (state == RFRT_TOKEN) begin
			ram[base + tok_slot] <= {1'b1,
				pcomp ? ack : ACK_NONE,
				tcode,
				cnt,
				spd,
				cfg[CFG_SNOOP],
				pcomp,
				cfg[CFG_SNOOP] ? snp_ack : 4'h0,
				7'h00};
		end else if (take) begin
			ram[base + (cnt == 9'h000 ? nxt(wp, rsize) : wp)] <= {1'b0, RX_DATA};
		end
	end

	// ==================================================
	// Receive block builder
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			state    <= RFRT_IDLE;
			wp       <= '0;
			cp       <= '0;
			tok_slot <= '0;
			cnt      <= '0;
			blocking <= 1'b0;
			pcomp    <= 1'b0;
			tcode    <= 4'h0;
			spd      <= 2'h0;
			ack      <= 4'h0;
			snp_ack  <= 4'h0;
		end else begin
			case (state)
				RFRT_IDLE, RFRT_RECV: begin
					if (take) begin
						if (RX_FIRST) begin
							spd      <= RX_SPEED;
							tcode    <= RX_KIND == RFRT_PK_NORMAL ? RX_TCODE : TCODE_SPECIAL;
							blocking <= trg_ok && RX_KIND == RFRT_PK_NORMAL && !RX_QUAD_PKT;
						end
						ack     <= RX_KIND == RFRT_PK_PHYLNK ? ACK_NONE : RX_ACK;
						snp_ack <= RX_SNOOP_ACK;
						if (cnt == 9'h000) begin
							tok_slot <= wp;
							wp       <= nxt(nxt(wp, rsize), rsize);
						end else begin
							wp <= nxt(wp, rsize);
						end
						cnt <= cnt + 9'h001;
						if (last_q) begin
							pcomp <= RX_LAST;
							state <= RFRT_TOKEN;
						end else begin
							state <= RFRT_RECV;
						end
					end
				end
				RFRT_TOKEN: begin
					cp    <= wp;
					cnt   <= '0;
					state <= pcomp ? RFRT_IDLE : RFRT_RECV;
				end
				default: state <= RFRT_IDLE;
			endcase
		end
	end

	// Fill counts reserved plus written words not yet read
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			fill <= '0;
			rp   <= '0;
		end else begin
			fill <= fill + (take ? (cnt == 9'h000 ? 9'h002 : 9'h001) : 9'h000) - (rd_recv ? 9'h001 : 9'h000);
			if (rd_recv)
				rp <= nxt(rp, rsize);
		end
	end

	// Stall is registered; four words of margin cover the token slot
	always_ff @(posedge REF_CLK) begin
		if (SRST)
			RX_READY <= 1'b0;
		else
			RX_READY <= !ram_test_enable && !take && state != RFRT_TOKEN && fill + 9'h004 < rsize;
	end

	// ==================================================
	// Host link answers
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			BUS.ack    <= 1'b0;
			BUS.rdata  <= '0;
			BUS.rx_irq <= 1'b0;
		end else begin
			BUS.ack    <= acc;
			BUS.rx_irq <= ready_blk && !ram_test_enable;
			if (acc && !BUS.wr) begin
				case (BUS.addr)
					DEV_CFG:    BUS.rdata <= cfg;
					DEV_PART:   BUS.rdata <= part;
					DEV_TXSTAT: BUS.rdata <= {7'h00, test_adr, 10'h000, ram_test_enable,
						test_control_value, 1'b0, control_mismatch_flag, 2'h0};
					DEV_RXSTAT: BUS.rdata <= ram_test_enable
						? {30'h0, ram[test_adr][CTRL_BIT], 1'b0}
						: {7'h00, ready_blk ? ram[head][TK_CNT +: AW] : 9'h000, 14'h0,
							ready_blk && ram[head][CTRL_BIT], ready_blk && ram[head][TK_PCOMP]};
					DEV_RXDATA: BUS.rdata <= ram_test_enable ? ram[test_adr][31:0]
						: (ready_blk ? ram[head][31:0] : 32'h0);
					default:    BUS.rdata <= 32'h0;
				endcase
			end
		end
	end
endmodule : rfrt_dev
`default_nettype wire

// ===== rtl/rfrt_host.sv
// Host bus master end: APB-programmed single accesses to the controller
`timescale 1ns/1ns
`default_nettype none
module rfrt_host (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        SRST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Host link
	rfrt_if.host             BUS
);
	import rfrt_pkg::*;

	// ==================================================
	// Registers
	logic [31:0] wdata_r, rdata_r;
	logic        refused, test_mode, pend_clr;
	logic        apb_acc, apb_wr, start, mapped;
	logic        cmd_wr;
	logic [7:0]  cmd_addr;

	assign apb_acc = PSEL && PENABLE && !PREADY;
	assign apb_wr  = apb_acc && PWRITE;
	assign cmd_wr  = PWDATA[HB_CMD_WR];
	assign cmd_addr = PWDATA[7:0];
	assign mapped  = PADDR == HB_CMD || PADDR == HB_WDATA || PADDR == HB_RDATA || PADDR == HB_STATUS;
	// Outside test mode, a receive read while no block is ready is refused
	assign start   = apb_wr && PADDR == HB_CMD && !BUS.cs
		&& (cmd_wr || cmd_addr != DEV_RXDATA || test_mode || BUS.rx_irq);

	// ==================================================
	// APB slave: one wait state, pready from a flop
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= '0;
		end else begin
			PREADY  <= apb_acc;
			PSLVERR <= apb_acc && !mapped;
			if (apb_acc && !PWRITE) begin
				case (PADDR)
					HB_WDATA:  PRDATA <= wdata_r;
					HB_RDATA:  PRDATA <= rdata_r;
					HB_STATUS: PRDATA <= {28'h0, test_mode, refused, BUS.rx_irq, BUS.cs || pend_clr};
					default:   PRDATA <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST)
			wdata_r <= '0;
		else if (apb_wr && PADDR == HB_WDATA)
			wdata_r <= PWDATA;
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST)
			refused <= 1'b0;
		else if (apb_wr && PADDR == HB_CMD)
			refused <= !start;
	end

	// ==================================================
	// Link master: request held until the acknowledge
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			BUS.cs    <= 1'b0;
			BUS.wr    <= 1'b0;
			BUS.addr  <= '0;
			BUS.wdata <= '0;
			rdata_r   <= '0;
			test_mode <= 1'b0;
			pend_clr  <= 1'b0;
		end else if (BUS.cs) begin
			if (BUS.ack) begin
				BUS.cs <= pend_clr;
				if (!BUS.wr)
					rdata_r <= BUS.rdata;
				// Entering test mode without the clear bit is followed by an address clear
				if (pend_clr) begin
					BUS.wdata <= BUS.wdata | (32'h1 << TX_ADR_CLEAR);
					pend_clr  <= 1'b0;
				end
			end
		end else if (start) begin
			BUS.cs    <= 1'b1;
			BUS.wr    <= cmd_wr;
			BUS.addr  <= cmd_addr;
			BUS.wdata <= wdata_r;
			if (cmd_wr && cmd_addr == DEV_TXSTAT) begin
				test_mode <= wdata_r[TX_TEST_EN];
				pend_clr  <= wdata_r[TX_TEST_EN] && !test_mode && !wdata_r[TX_ADR_CLEAR];
			end
		end
	end
endmodule : rfrt_host
`default_nettype wire

// ===== bench/rfrt_asserts.sv
// Link-bus checker for the host and controller ends
`timescale 1ns/1ns
`default_nettype none
module rfrt_asserts (
	// Clock and reset
	input wire logic        REF_CLK,
	input wire logic        SRST,
	// Link signals
	input wire logic        cs,
	input wire logic        wr,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic [31:0] rdata,
	input wire logic        ack,
	input wire logic        rx_irq
);
	import rfrt_pkg::*;
	// ==================================================
	// Shadow of test mode, address counter and mismatch
	logic       test;
	logic       mm_seen;
	logic [8:0] cnt;
	wire logic  wr0c = ack && wr && addr == DEV_TXSTAT;
	wire logic  rd0c = ack && !wr && addr == DEV_TXSTAT;
	wire logic  c0t  = ack && test && addr == DEV_RXDATA;
	always_ff @(posedge REF_CLK) begin
		if (SRST) test <= 1'b0;
		else if (wr0c) test <= wdata[TX_TEST_EN];
	end
	always_ff @(posedge REF_CLK) begin
		if (SRST) cnt <= 9'h000;
		else if (wr0c) cnt <= wdata[TX_ADR_CLEAR] ? 9'h000 : wdata[TX_ADR_LSB +: 9];
		else if (c0t) cnt <= cnt + 9'h001;
	end
	// Only a test read can set the mismatch, so until one happens it must read 0
	always_ff @(posedge REF_CLK) begin
		if (SRST) mm_seen <= 1'b0;
		else if (wr0c && wdata[TX_ADR_CLEAR]) mm_seen <= 1'b0;
		else if (c0t && !wr) mm_seen <= 1'b1;
	end
	// ==================================================
	// Properties
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	a_ack_next_cycle: assert property (cs && !ack |=> ack)
		else $error("request not answered next cycle");
	a_ack_one_pulse: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	a_ack_has_cause: assert property (ack |-> $past(cs) && !$past(ack))
		else $error("ack without request");
	a_irq_quiet_test: assert property (test |-> !rx_irq)
		else $error("data-ready raised in test mode");
	a_test_bit_back: assert property (rd0c |-> rdata[TX_TEST_EN] == test)
		else $error("test mode bit reads wrong");
	a_adr_count: assert property (rd0c && test |-> rdata[TX_ADR_LSB +: 9] == cnt)
		else $error("address counter wrong");
	a_clr_self: assert property (rd0c |-> !rdata[TX_ADR_CLEAR])
		else $error("address clear did not clear itself");
	a_clr_mismatch: assert property (rd0c && !mm_seen |-> !rdata[TX_MISMATCH])
		else $error("mismatch set without test read");
endmodule : rfrt_asserts
`default_nettype wire

// ===== bench/tb_receive_fifo_read_and_ram_test.sv
// Bench joining the host and controller ends across the link
`timescale 1ns/1ns
`default_nettype none
module tb_receive_fifo_read_and_ram_test;
	import rfrt_pkg::*;
	localparam logic [31:0] MK = 32'hFFFF_FF80;
	logic        clk, srst, psel, pen, pwr, prdy, perr, lerr;
	logic        rv, rf, rl, rq, rrdy;
	logic [7:0]  paddr;
	logic [31:0] pwd, prd, rdat, r0;
	logic [3:0]  rtc, rak, rsa;
	logic [1:0]  rsp;
	rfrt_kind_t  rk;
	int          num_errors, n_checks;
	int          cyc = 0;
	rfrt_if      link ();
	rfrt_host rfrt_host_inst (.REF_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .BUS(link.host));
	rfrt_dev rfrt_dev_inst (.REF_CLK(clk), .SRST(srst), .BUS(link.dev), .RX_VALID(rv), .RX_FIRST(rf),
		.RX_LAST(rl), .RX_DATA(rdat), .RX_TCODE(rtc), .RX_SPEED(rsp), .RX_KIND(rk), .RX_QUAD_PKT(rq),
		.RX_ACK(rak), .RX_SNOOP_ACK(rsa), .RX_READY(rrdy));
	rfrt_asserts rfrt_asserts_inst (.REF_CLK(clk), .SRST(srst), .cs(link.cs), .wr(link.wr),
		.addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .rx_irq(link.rx_irq));
	// ==================================================
	// Shared tasks
	task automatic chk(input logic [31:0] g, e, input string m);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		r = prd;
		lerr = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic dacc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		apb(1'b1, HB_WDATA, d, r);
		apb(1'b1, HB_CMD, {23'h0, w, a}, r);
		do apb(1'b0, HB_STATUS, 32'h0, r); while (r[HB_ST_BUSY] !== 1'b0);
		apb(1'b0, HB_RDATA, 32'h0, r);
	endtask : dacc
	function automatic logic [31:0] tokf(logic [3:0] ak, tc, logic [8:0] n, logic [1:0] sp, logic sn, pc,
		logic [3:0] sa);
		return {ak, tc, n, sp, sn, pc, sa, 7'h00};
	endfunction : tokf
	// Beats follow the ready handshake; the pause lets the token land and the flag rise
	task automatic send(input int n, input rfrt_kind_t k, input logic q, input logic [3:0] tc, input logic [1:0] sp);
		rv <= 1'b1;
		rk <= k;
		rq <= q;
		rtc <= tc;
		rsp <= sp;
		for (int i = 0; i < n; i++) begin
			rf <= (i == 0);
			rl <= (i == n - 1);
			rdat <= 32'hA5A5_0000 + i[31:0];
			do @(posedge clk); while (rrdy !== 1'b1);
		end
		rv <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : send
	task automatic rdblk(input logic [31:0] tok, m, input int n, s);
		logic [31:0] r;
		chk(link.rx_irq, 1'b1, "irq");
		dacc(1'b0, DEV_RXSTAT, 32'h0, r);
		chk({r[RX_CNT_LSB +: 9], r[RX_HEADFLAG], r[RX_PKT_DONE]}, {n[8:0], 1'b1, tok[TK_PCOMP]}, "rx status");
		dacc(1'b0, DEV_RXDATA, 32'h0, r);
		chk(r & m, tok & m, "token");
		for (int i = s; i < s + n; i++) begin
			dacc(1'b0, DEV_RXDATA, 32'h0, r);
			chk(r, 32'hA5A5_0000 + i[31:0], "quadlet");
		end
	endtask : rdblk
	// ==================================================
	// Scenarios
	task automatic t_token();
		logic [31:0] r;
		for (int s = 0; s < 3; s++) begin
			send(2, RFRT_PK_NORMAL, 1'b0, 4'h1, s[1:0]);
			rdblk(tokf(rak, 4'h1, 9'h002, s[1:0], 1'b0, 1'b1, 4'h0), MK, 2, 0);
		end
		repeat (4) @(posedge clk);
		chk(link.rx_irq, 1'b0, "irq after drain");
		// A receive read with nothing ready must not reach the controller
		dacc(1'b0, DEV_RXDATA, 32'h0, r);
		apb(1'b0, HB_STATUS, 32'h0, r);
		chk(r[HB_ST_REF], 1'b1, "empty read refused");
	endtask : t_token
	task automatic t_special();
		logic [31:0] r;
		dacc(1'b1, DEV_CFG, 32'h0000_0001, r);
		send(1, RFRT_PK_PHYLNK, 1'b0, 4'h3, 2'h2);
		rdblk(tokf(4'h0, TCODE_SPECIAL, 9'h001, 2'h2, 1'b1, 1'b1, rsa), MK, 1, 0);
		dacc(1'b1, DEV_CFG, 32'h0, r);
	endtask : t_special
	task automatic t_ram();
		logic [31:0] r, st;
		// A block left pending across test mode shows whether status is kept
		send(2, RFRT_PK_NORMAL, 1'b0, 4'h1, 2'h0);
		dacc(1'b0, DEV_RXSTAT, 32'h0, st);
		dacc(1'b1, DEV_TXSTAT, 32'h0000_0030, r);
		dacc(1'b1, DEV_TXSTAT, 32'h0080_0030, r);
		chk(rrdy, 1'b0, "stream halted in test");
		dacc(1'b0, DEV_RXSTAT, 32'h0, r);
		chk(r[RX_HEADFLAG], 1'b1, "stored ctrl");
		dacc(1'b0, DEV_RXDATA, 32'h0, r);
		chk(r & MK, tokf(4'h1, 4'h1, 9'h002, 2'h0, 1'b0, 1'b1, 4'h0) & MK, "receive base");
		dacc(1'b0, DEV_RXDATA, 32'h0, r);
		chk(r, 32'hA5A5_0000, "next word");
		dacc(1'b0, DEV_TXSTAT, 32'h0, r);
		chk(r & 32'h01FF_0014, 32'h0082_0014, "counter, mismatch");
		dacc(1'b1, DEV_TXSTAT, 32'h0000_0038, r);
		dacc(1'b0, DEV_TXSTAT, 32'h0, r);
		chk(r & 32'h01FF_003C, 32'h0000_0030, "address clear");
		dacc(1'b1, DEV_RXDATA, 32'h1234_5678, r);
		dacc(1'b1, DEV_TXSTAT, 32'h0000_0020, r);
		dacc(1'b0, DEV_RXDATA, 32'h0, r);
		chk(r, 32'h1234_5678, "test write");
		dacc(1'b0, DEV_TXSTAT, 32'h0, r);
		chk(r & 32'h01FF_0014, 32'h0001_0004, "ctrl bit 1 vs 0");
		dacc(1'b1, DEV_TXSTAT, 32'h01FF_0020, r);
		dacc(1'b1, DEV_RXDATA, 32'h0, r);
		dacc(1'b0, DEV_TXSTAT, 32'h0, r);
		chk(r[TX_ADR_LSB +: 10], 10'h000, "wrap at 512");
		dacc(1'b1, DEV_TXSTAT, 32'h0, r);
		apb(1'b0, HB_STATUS, 32'h0, r);
		chk(r[HB_ST_TEST], 1'b0, "test mode left");
		dacc(1'b0, DEV_RXSTAT, 32'h0, r);
		chk(r, st, "status kept");
		rdblk(tokf(rak, 4'h1, 9'h002, 2'h0, 1'b0, 1'b1, 4'h0), MK, 2, 0);
	endtask : t_ram
	task automatic t_trig();
		logic [31:0] r;
		logic [31:0] cf [2] = '{32'h0000_0606, 32'h0000_0502};
		foreach (cf[j]) begin
			dacc(1'b1, DEV_CFG, cf[j], r);
			send(7, RFRT_PK_NORMAL, 1'b0, 4'h1, 2'h0);
			rdblk(tokf(rak, 4'h1, 9'h007, 2'h0, 1'b0, 1'b1, 4'h0), MK, 7, 0);
		end
		dacc(1'b1, DEV_CFG, 32'h0000_0602, r);
		send(8, RFRT_PK_SELFID, 1'b0, 4'h1, 2'h0);
		rdblk(tokf(rak, TCODE_SPECIAL, 9'h008, 2'h0, 1'b0, 1'b1, 4'h0), MK, 8, 0);
		send(8, RFRT_PK_NORMAL, 1'b1, 4'h1, 2'h0);
		rdblk(tokf(rak, 4'h1, 9'h008, 2'h0, 1'b0, 1'b1, 4'h0), MK, 8, 0);
		send(14, RFRT_PK_NORMAL, 1'b0, 4'h7, 2'h2);
		rdblk(tokf(rak, 4'h7, 9'h006, 2'h2, 1'b0, 1'b0, 4'h0), 32'h0FFF_FF80, 6, 0);
		rdblk(tokf(rak, 4'h7, 9'h006, 2'h2, 1'b0, 1'b0, 4'h0), 32'h0FFF_FF80, 6, 6);
		rdblk(tokf(rak, 4'h7, 9'h002, 2'h2, 1'b0, 1'b1, 4'h0), MK, 2, 12);
	endtask : t_trig
	task automatic t_unmapped();
		apb(1'b0, 8'h40, 32'h0, r0);
		chk(lerr, 1'b1, "unmapped host address");
	endtask : t_unmapped
	task automatic wrap_up();
		$display("Checks: %0d, errors: %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up
	// ==================================================
	// Clock, watchdog and main sequence
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			$display("CHECK FAILED at %0t: timeout", $time);
			wrap_up();
		end
	end
	initial begin
		srst = 1'b1;
		{psel, pen, pwr, rv, rf, rl, rq, lerr} = 8'h00;
		{paddr, pwd, rdat, rtc, rsp} = 78'h0;
		rk = RFRT_PK_NORMAL;
		rak = 4'h1;
		rsa = 4'h9;
		num_errors = 0;
		n_checks = 0;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		t_token();
		t_special();
		t_ram();
		t_trig();
		t_unmapped();
		wrap_up();
	end
endmodule : tb_receive_fifo_read_and_ram_test
`default_nettype wire
